//--- bench/tcoc_assertions.sv
`timescale 1ns/1ns
module tcoc_chk (
  input wire        clk_in,
  input wire        rst_n_in,
  input wire        count_tick_in,
  input wire [3:0]  chan_irq_in,
  input wire [3:0]  chan_start_in,
  input wire [3:0]  chan_irq_out,
  input wire [3:0]  chan_out_pin_out,
  input wire        s_axi_awready,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  //--------------------------------------------
  // Timer side
  //--------------------------------------------
  irq_pass_a: assert property (
    chan_irq_in != 4'h0 |=> (chan_irq_out & $past(chan_irq_in)) == $past(chan_irq_in))
    else $error("timer interrupt not passed on");
  irq_cause_a: assert property (
    (chan_irq_out & ~($past(chan_irq_in) | $past(chan_start_in))) == 4'h0)
    else $error("interrupt without cause");
  // Only events or an accepted write may move a pin
  pin_cause_a: assert property (
    $changed(chan_out_pin_out) |-> $rose(s_axi_bvalid) || $past(count_tick_in)
      || ($past(chan_irq_in) | $past(chan_start_in)) != 4'h0)
    else $error("pin moved without cause");
  //--------------------------------------------
  // Register bus
  //--------------------------------------------
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  r_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  w_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while busy");
  r_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
endmodule // tcoc_chk

bind tcoc_top tcoc_chk i_tcoc_chk (
  .clk_in           (clk_in),
  .rst_n_in         (rst_n_in),
  .count_tick_in    (count_tick_in),
  .chan_irq_in      (chan_irq_in),
  .chan_start_in    (chan_start_in),
  .chan_irq_out     (chan_irq_out),
  .chan_out_pin_out (chan_out_pin_out),
  .s_axi_awready    (s_axi_awready),
  .s_axi_wready     (s_axi_wready),
  .s_axi_bvalid     (s_axi_bvalid),
  .s_axi_bready     (s_axi_bready),
  .s_axi_bresp      (s_axi_bresp),
  .s_axi_arvalid    (s_axi_arvalid),
  .s_axi_arready    (s_axi_arready),
  .s_axi_rvalid     (s_axi_rvalid),
  .s_axi_rready     (s_axi_rready),
  .s_axi_rdata      (s_axi_rdata)
);

//--- bench/testbench.sv
`timescale 1ns/1ns
`include "tcoc_regs.vh"
module testbench;
  logic        clk_in, rst_n_in, count_tick_in, s_axi_awvalid, s_axi_awready;
  logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0]  chan_irq_in, chan_start_in, chan_irq_out, chan_out_pin_out, s_axi_wstrb, ep;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, lf;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  integer      err_count, cmp_count, i, k;
  logic        late;
  // Slave steps: irq, tick, expected pins
  logic [8:0]  st [0:8] = '{9'h021, 9'h017, 9'h045, 9'h024, 9'h092,
                            9'h01a, 9'h08e, 9'h02f, 9'h01b};
  tcoc_top i_tcoc_top (.*);
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Latch after a collective write: enabled bits keep their level
  function [3:0] exp_wr(input [3:0] cur, input [3:0] wr, input [3:0] en);
    exp_wr = (cur & en) | (wr & ~en);
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("errors %0d compares %0d", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task tmo;
    if (i >= 20) begin
      err_count = err_count + 1;
      print_verdict;
    end
  endtask
  // Readies sampled at the falling edge, where they are settled
  task bus(input w_op, input [7:0] a, input [31:0] d);
    logic p_aw, p_w, p_ar;
    begin
      @(posedge clk_in);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      {p_aw, p_w, p_ar} = {w_op, w_op, !w_op};
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {p_aw, p_w, p_ar};
      {s_axi_bready, s_axi_rready} <= {w_op & !late, !w_op & !late};
      for (i = 0; i < 20 && (p_aw || p_w || p_ar); i = i + 1) begin
        @(negedge clk_in);
        {p_aw, p_w} = {p_aw & !s_axi_awready, p_w & !s_axi_wready};
        p_ar = p_ar & !s_axi_arready;
        @(posedge clk_in);
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {p_aw, p_w, p_ar};
      end
      tmo;
      i = 0;
      @(negedge clk_in);
      while (i < 20 && !(s_axi_bvalid || s_axi_rvalid)) begin
        @(negedge clk_in);
        i = i + 1;
      end
      tmo;
      rd = s_axi_rdata;
      rs = w_op ? s_axi_bresp : s_axi_rresp;
      // Late ready keeps the response waiting for a cycle
      if (late) begin
        @(posedge clk_in);
        {s_axi_bready, s_axi_rready} <= {w_op, !w_op};
      end
      @(posedge clk_in);
      {s_axi_bready, s_axi_rready} <= 2'h0;
      @(negedge clk_in);
    end
  endtask
  task pulse(input [3:0] q, input [3:0] s, input t);
    begin
      @(posedge clk_in);
      {chan_irq_in, chan_start_in, count_tick_in} <= {q, s, t};
      @(posedge clk_in);
      {chan_irq_in, chan_start_in, count_tick_in} <= 9'h000;
      @(negedge clk_in);
    end
  endtask
  initial begin
    {err_count, cmp_count, lf, late} = {32'h0, 32'h0, 32'h40ab, 1'b0};
    s_axi_wstrb <= 4'hf;
    {rst_n_in, count_tick_in, chan_irq_in, chan_start_in, s_axi_awvalid, s_axi_wvalid,
     s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr,
     s_axi_awprot, s_axi_arprot, s_axi_wdata} <= '0;
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    for (k = 0; k < 7; k = k + 1) begin
      late = k[0];
      bus(0, 8'h04 * k, 32'h0);
      chk(rd, 32'h0);
      chk(rs, k == 6 ? `TCOC_RESP_SLVERR : `TCOC_RESP_OKAY);
    end
    bus(1, 8'h18, 32'hf);
    chk(rs, `TCOC_RESP_SLVERR);
    chk(chan_out_pin_out, 4'h0);
    // Write with no byte lane must leave the register alone
    late = 1'b1;
    @(posedge clk_in);
    s_axi_wstrb <= 4'h0;
    bus(1, `TCOC_OFF_ENABLE, 32'hf);
    chk(rs, `TCOC_RESP_OKAY);
    late = 1'b0;
    @(posedge clk_in);
    s_axi_wstrb <= 4'hf;
    bus(0, `TCOC_OFF_ENABLE, 32'h0);
    chk(rd, 32'h0);
    bus(1, `TCOC_OFF_LATCH, 32'ha);
    chk(chan_out_pin_out, exp_wr(4'h0, 4'ha, 4'h0));
    pulse(4'hf, 4'hf, 1'b1);
    chk(chan_out_pin_out, 4'ha);
    bus(0, `TCOC_OFF_LATCH, 32'h0);
    chk(rd, 32'ha);
    bus(1, `TCOC_OFF_POLARITY, 32'hf);
    bus(1, `TCOC_OFF_ENABLE, 32'hf);
    bus(1, `TCOC_OFF_LATCH, 32'h5);
    chk(chan_out_pin_out, exp_wr(4'ha, 4'h5, 4'hf));
    ep = 4'ha;
    for (k = 0; k < 8; k = k + 1) begin
      lf = lfsr(lf);
      pulse(lf[3:0], 4'h0, lf[4]);
      ep = ep ^ lf[3:0];
      chk(chan_out_pin_out, ep);
      chk(chan_irq_out, lf[3:0]);
    end
    bus(1, `TCOC_OFF_TMODE, 32'he4);
    bus(1, `TCOC_OFF_START_SEL, 32'hf);
    pulse(4'h0, 4'hf, 1'b0);
    ep = ep ^ 4'h3;
    chk(chan_out_pin_out, ep);
    chk(chan_irq_out, 4'h3);
    bus(1, `TCOC_OFF_START_SEL, 32'h0);
    pulse(4'h0, 4'hf, 1'b0);
    chk(chan_out_pin_out, ep);
    chk(chan_irq_out, 4'h0);
    bus(1, `TCOC_OFF_ENABLE, 32'h5);
    bus(1, `TCOC_OFF_LATCH, 32'hf);
    chk(chan_out_pin_out, exp_wr(ep, 4'hf, 4'h5));
    bus(1, `TCOC_OFF_ENABLE, 32'h0);
    bus(1, `TCOC_OFF_MODE, 32'he);
    bus(1, `TCOC_OFF_POLARITY, 32'h0);
    bus(1, `TCOC_OFF_LATCH, 32'h0);
    chk(chan_out_pin_out, 4'h0);
    bus(1, `TCOC_OFF_ENABLE, 32'hf);
    for (k = 0; k < 9; k = k + 1) begin
      if (k == 6) begin
        bus(1, `TCOC_OFF_POLARITY, 32'h4);
        chk(chan_out_pin_out, 4'ha);
      end
      pulse(st[k][8:5], 4'h0, st[k][4]);
      chk(chan_out_pin_out, st[k][3:0]);
    end
    // Reset in mid-run must bring every pin back to its idle level
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    bus(0, `TCOC_OFF_ENABLE, 32'h0);
    chk(rd, 32'h0);
    chk(chan_out_pin_out, 4'h0);
    print_verdict;
  end
endmodule // testbench

//--- rtl/tcoc_chan_out.v
`timescale 1ns/1ns
`include "tcoc_regs.vh"

module tcoc_chan_out (
  input  wire clk_in,
  input  wire rst_n_in,
  input  wire tick_in,
  input  wire own_irq_in,
  input  wire master_irq_in,
  input  wire mode_in,
  input  wire pol_in,
  input  wire enable_in,
  input  wire sw_wr_in,
  input  wire sw_data_in,
  output wire level_out
);

  reg  level_r;
  reg  level_nxt;
  reg  set_pend_r;
  reg  set_pend_nxt;
  wire slave_act;
  wire set_ev;
  wire reset_ev;

  assign slave_act = mode_in & enable_in;
  assign set_ev    = slave_act & set_pend_r & tick_in;
  assign reset_ev  = slave_act & own_irq_in;
  assign level_out = level_r;

  always @* begin
    set_pend_nxt = slave_act & (master_irq_in | (set_pend_r & ~tick_in));
    level_nxt    = level_r;
    if (!enable_in) begin
      if (sw_wr_in) begin
        level_nxt = sw_data_in;
      end
    end else if (!mode_in) begin
      if (own_irq_in) begin
        level_nxt = ~level_r;
      end
    end else if (reset_ev) begin
      level_nxt = pol_in;
    end else if (set_ev) begin
      level_nxt = ~pol_in;
    end
  end

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      level_r    <= 1'b0;
      set_pend_r <= 1'b0;
    end else begin
      level_r    <= level_nxt;
      set_pend_r <= set_pend_nxt;
    end
  end

endmodule // tcoc_chan_out

//--- rtl/tcoc_regs.vh
//------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------
// Summary of operation
// - Master mode: each own interrupt toggles output
// - Slave mode: master and slave interrupts drive
// - Polarity 0: master sets, slave resets
// - Simultaneous set and reset: reset wins
// - Enabled: software latch writes ignored
// - Disabled: software writes land, interrupts do not move the pin
// - Latch register always reads current levels
// - Output settings never disturb counter operation
// - Master mode start toggles programmed level
// - Polarity change acts at next event
// - Slave mode set delayed one count tick
// - Collective write touches only disabled channels
// - Interval/capture: start interrupt when selected
// - Other modes: nothing happens at start
// - Masters 0 and 2; slaves numbered higher
`ifndef TCOC_REGS_VH
`define TCOC_REGS_VH

`define TCOC_NCH            4
`define TCOC_ADDR_W         8

// Register byte offsets
`define TCOC_OFF_LATCH      8'h00
`define TCOC_OFF_ENABLE     8'h04
`define TCOC_OFF_POLARITY   8'h08
`define TCOC_OFF_MODE       8'h0c
`define TCOC_OFF_START_SEL  8'h10
`define TCOC_OFF_TMODE      8'h14

// Reset values
`define TCOC_RST_CH         4'h0
`define TCOC_RST_TMODE      8'h00

// Counter operating modes, two bits per channel
`define TCOC_TM_INTERVAL    2'h0
`define TCOC_TM_CAPTURE     2'h1
`define TCOC_TM_EVENT       2'h2
`define TCOC_TM_ONECOUNT    2'h3

// AXI responses
`define TCOC_RESP_OKAY      2'h0
`define TCOC_RESP_SLVERR    2'h2

`endif

//--- rtl/tcoc_top.v
`timescale 1ns/1ns
`include "tcoc_regs.vh"

module tcoc_top (
  input  wire        clk_in,
  input  wire        rst_n_in,
  // Timer side
  input  wire        count_tick_in,
  input  wire [3:0]  chan_irq_in,
  input  wire [3:0]  chan_start_in,
  output wire [3:0]  chan_irq_out,
  output wire [3:0]  chan_out_pin_out,
  // AXI4-Lite write address
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [7:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  // AXI4-Lite write data
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  output wire [1:0]  s_axi_bresp,
  // AXI4-Lite read address
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  input  wire [7:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  // AXI4-Lite read data
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp
);

  //----------------------------------------------------------
  // Configuration registers
  //----------------------------------------------------------
  reg  [3:0]  enable_r;
  reg  [3:0]  polarity_r;
  reg  [3:0]  mode_r;
  reg  [3:0]  start_sel_r;
  reg  [7:0]  tmode_r;
  wire [3:0]  latch_level;

  //----------------------------------------------------------
  // AXI write channel state
  //----------------------------------------------------------
  reg         aw_held_r;
  reg  [7:0]  aw_addr_r;
  reg         w_held_r;
  reg  [31:0] w_data_r;
  reg  [3:0]  w_strb_r;
  reg         bvalid_r;
  reg  [1:0]  bresp_r;
  wire        wr_fire;
  wire        wr_lane0;
  wire        wr_hit;

  //----------------------------------------------------------
  // AXI read channel state
  //----------------------------------------------------------
  reg         rvalid_r;
  reg  [31:0] rdata_r;
  reg  [1:0]  rresp_r;
  reg  [31:0] rd_mux;
  reg         rd_hit;
  wire        rd_fire;

  //----------------------------------------------------------
  // Event plumbing
  //----------------------------------------------------------
  wire [3:0]  start_irq;
  wire [3:0]  own_irq;
  wire [3:0]  master_irq;
  wire [3:0]  latch_wr;
  reg  [3:0]  irq_out_r;

  // Address and data captured independently, in either order
  assign s_axi_awready = ~aw_held_r & ~bvalid_r;
  assign s_axi_wready  = ~w_held_r & ~bvalid_r;
  assign wr_fire       = aw_held_r & w_held_r & ~bvalid_r;
  assign wr_lane0      = w_strb_r[0];
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;

  assign wr_hit = (aw_addr_r == `TCOC_OFF_LATCH)    |
                  (aw_addr_r == `TCOC_OFF_ENABLE)   |
                  (aw_addr_r == `TCOC_OFF_POLARITY) |
                  (aw_addr_r == `TCOC_OFF_MODE)     |
                  (aw_addr_r == `TCOC_OFF_START_SEL)|
                  (aw_addr_r == `TCOC_OFF_TMODE);

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_held_r  <= 1'b0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `TCOC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_hit ? `TCOC_RESP_OKAY : `TCOC_RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  //----------------------------------------------------------
  // Register writes
  //----------------------------------------------------------
  // Only the low byte carries fields; other lanes are ignored.
  // None of these touch counters, so they may change at run time.
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      enable_r    <= `TCOC_RST_CH;
      polarity_r  <= `TCOC_RST_CH;
      mode_r      <= `TCOC_RST_CH;
      start_sel_r <= `TCOC_RST_CH;
      tmode_r     <= `TCOC_RST_TMODE;
    end else if (wr_fire && wr_lane0) begin
      case (aw_addr_r)
        `TCOC_OFF_ENABLE:    enable_r    <= w_data_r[3:0];
        `TCOC_OFF_POLARITY:  polarity_r  <= w_data_r[3:0];
        `TCOC_OFF_MODE:      mode_r      <= w_data_r[3:0];
        `TCOC_OFF_START_SEL: start_sel_r <= w_data_r[3:0];
        `TCOC_OFF_TMODE:     tmode_r     <= w_data_r[7:0];
        default: begin
        end
      endcase
    end
  end

  // Latch write strobe per bit; enabled channels drop their bit
  assign latch_wr = (wr_fire && wr_lane0 && aw_addr_r == `TCOC_OFF_LATCH) ?
                    ~enable_r : 4'h0;

  //----------------------------------------------------------
  // Read path
  //----------------------------------------------------------
  assign s_axi_arready = ~rvalid_r;
  assign rd_fire       = s_axi_arvalid & ~rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  always @* begin
    rd_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case ({s_axi_araddr[7:2], 2'h0})
      `TCOC_OFF_LATCH:     rd_mux[3:0] = latch_level;
      `TCOC_OFF_ENABLE:    rd_mux[3:0] = enable_r;
      `TCOC_OFF_POLARITY:  rd_mux[3:0] = polarity_r;
      `TCOC_OFF_MODE:      rd_mux[3:0] = mode_r;
      `TCOC_OFF_START_SEL: rd_mux[3:0] = start_sel_r;
      `TCOC_OFF_TMODE:     rd_mux[7:0] = tmode_r;
      default:             rd_hit = 1'b0;
    endcase
  end

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= `TCOC_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_mux;
      rresp_r  <= rd_hit ? `TCOC_RESP_OKAY : `TCOC_RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  //----------------------------------------------------------
  // Per channel output stage
  //----------------------------------------------------------
  genvar n;
  generate
    for (n = 0; n < `TCOC_NCH; n = n + 1) begin : g_ch
      wire [1:0] tm;
      wire       start_ok;
      assign tm       = tmode_r[2*n+1:2*n];
      // Only interval and capture counters announce their start
      assign start_ok = (tm == `TCOC_TM_INTERVAL) | (tm == `TCOC_TM_CAPTURE);
      assign start_irq[n] = chan_start_in[n] & start_sel_r[n] & start_ok;
      // Start interrupt also toggles a master-mode output
      assign own_irq[n] = chan_irq_in[n] | start_irq[n];

      // Masters are 0 and 2; 1 and 2 follow 0, 3 follows 2
      if (n == 0) begin : g_m0
        assign master_irq[n] = 1'b0;
      end else if (n == 3) begin : g_m2
        assign master_irq[n] = own_irq[2];
      end else begin : g_m1
        assign master_irq[n] = own_irq[0];
      end

      tcoc_chan_out u_out (
        .clk_in        (clk_in),
        .rst_n_in      (rst_n_in),
        .tick_in       (count_tick_in),
        .own_irq_in    (own_irq[n]),
        .master_irq_in (master_irq[n]),
        .mode_in       (mode_r[n]),
        .pol_in        (polarity_r[n]),
        .enable_in     (enable_r[n]),
        .sw_wr_in      (latch_wr[n]),
        .sw_data_in    (w_data_r[n]),
        .level_out     (latch_level[n])
      );
    end
  endgenerate

  //----------------------------------------------------------
  // Outputs
  //----------------------------------------------------------
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      irq_out_r <= 4'h0;
    end else begin
      irq_out_r <= own_irq;
    end
  end

  assign chan_irq_out     = irq_out_r;
  assign chan_out_pin_out = latch_level;

endmodule // tcoc_top
